// ### hw/fprs_pkg.sv
// Purpose: Shared constants and types for the floating-point register stack
// Assumes: One core clock, synchronous active-high reset
// Notes: Storage is eight 80-bit slots addressed relative to the stack top, except media writes, which use an absolute slot index
package fprs_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int FPRS_SLOTS = 8;
    localparam int FPRS_IDX_W = 3;
    localparam int FPRS_EXT_W = 80;
    localparam int FPRS_MEM_W = 80;
    localparam int FPRS_MEDIA_W = 64;
    localparam int FPRS_WORD_W = 16;
    localparam int FPRS_IP_W = 32;
    localparam int FPRS_OPC_W = 11;

    // ****************************************
    // Status word fields and reset values
    // ****************************************
    localparam int FPRS_TOP_LSB = 11;
    localparam int FPRS_TOP_MSB = 13;
    localparam int FPRS_C1_BIT = 9;
    localparam int FPRS_SF_BIT = 6;
    localparam int FPRS_IE_BIT = 0;
    localparam logic [2:0] FPRS_TOP_RST = 3'h0;
    localparam logic [15:0] FPRS_STATUS_RST = 16'h0000;
    localparam logic [15:0] FPRS_CTRL_RST = 16'h037F;
    localparam logic [15:0] FPRS_TAG_RST = 16'hFFFF;
    localparam logic [1:0] FPRS_TAG_VALID = 2'h0;
    localparam logic [1:0] FPRS_TAG_EMPTY = 2'h3;
    localparam logic [15:0] FPRS_MEDIA_EXP = 16'hFFFF;

    // ****************************************
    // Operations and formats
    // ****************************************
    typedef enum logic [2:0] {
        FPRS_OP_NONE, FPRS_OP_PUSH, FPRS_OP_POP, FPRS_OP_LOAD,
        FPRS_OP_STORE, FPRS_OP_SWAP, FPRS_OP_MEDIA_WR, FPRS_OP_WRITE
    } fprs_op_t;

    typedef enum logic [1:0] {
        FPRS_FMT_EXT, FPRS_FMT_INT, FPRS_FMT_BCD
    } fprs_fmt_t;

    typedef struct packed {
        logic valid;
        fprs_op_t op;
        fprs_fmt_t fmt;
        logic [2:0] relIdx;
        logic [FPRS_MEM_W-1:0] data;
        logic [FPRS_IP_W-1:0] instrPtr;
        logic [FPRS_IP_W-1:0] operandPtr;
        logic [FPRS_OPC_W-1:0] opcode;
    } fprs_req_t;

    typedef struct packed {
        logic valid;
        logic [FPRS_MEM_W-1:0] data;
        logic [FPRS_EXT_W-1:0] headValue;
    } fprs_rsp_t;
endpackage : fprs_pkg

// ### hw/fprs_stack.sv
// Purpose: Eight-slot floating-point data register stack with stack top pointer
// Assumes: Core issues at most one request per cycle from its normal stream
// Notes: Conversion normalizes and truncates; full rounding lives elsewhere
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Eight 80-bit extended-precision data registers
// - Loads convert integer or decimal to extended
// - Stores emit extended, integer or decimal format
// - All accesses except media writes resolve relative to stack head
// - Push decrements pointer then writes new head
// - Pop reads head, stores, then increments pointer
// - Plain load/store leaves pointer unchanged
// - Push at pointer zero wraps to seven
// - Overflow flagged when push hits unsaved slot
// - Relative index i selects i-th from head
// - Swap exchanges head with another slot
// - Calls and returns leave registers untouched
// - Multimedia registers alias the same storage
// - Other execution state cannot alter this
// - Six special registers kept beside data
// - Requests arrive from the normal instruction stream
// - Pointer sits in status bits 11 to 13
module fprs_stack (
    input wire logic core_clk,
    input wire logic reset,
    input wire fprs_pkg::fprs_req_t req,
    input wire logic [15:0] ctrlWrData,
    input wire logic ctrlWrEn,
    input wire logic clearExc,
    output var fprs_pkg::fprs_rsp_t rsp,
    output logic [15:0] statusWord,
    output logic [15:0] controlWord,
    output logic [15:0] tagWord,
    output logic [31:0] lastInstrPtr,
    output logic [31:0] lastOperandPtr,
    output logic [10:0] lastOpcode,
    output logic stackOverflow
);
    import fprs_pkg::*;

    // ****************************************
    // State
    // ****************************************
    logic [FPRS_EXT_W-1:0] slotMem_q [FPRS_SLOTS];
    logic [FPRS_SLOTS-1:0] slotFull_q;
    wire logic [FPRS_SLOTS-1:0] slotFull_d;
    wire logic [15:0] tag_d;
    logic [2:0] top_q;
    logic [2:0] topPush;
    logic [2:0] topPop;
    logic [2:0] headIdx;
    logic [2:0] relPhys;
    logic [FPRS_EXT_W-1:0] loadExt;
    logic [FPRS_MEM_W-1:0] storeMem;
    logic overflowHit;
    logic exc_q;

    // ****************************************
    // Addressing
    // ****************************************
    // Every access goes through the head except media writes, which index slotMem_q by req.relIdx directly
    assign headIdx = top_q;
    assign relPhys = top_q + req.relIdx;
    assign topPush = top_q - 3'h1;
    assign topPop = top_q + 3'h1;
    assign overflowHit = req.valid && req.op == FPRS_OP_PUSH && slotFull_q[topPush];

    // ****************************************
    // Format conversion
    // ****************************************
    // Integer path: absolute value normalized into the significand, sign taken from bit 63
    function automatic logic [FPRS_EXT_W-1:0] toExt(input fprs_fmt_t f,
                                                      input logic [FPRS_MEM_W-1:0] d);
        logic [63:0] mag;
        logic [6:0] lz;
        logic [63:0] norm;
        mag = 64'h0;
        lz = 7'h0;
        norm = 64'h0;
        if (f == FPRS_FMT_EXT) begin
            return d;
        end
        if (f == FPRS_FMT_BCD) begin
            mag = 64'h0;
            for (int k = 17; k >= 0; k--) begin
                mag = (mag * 64'hA) + 64'(d[k*4 +: 4]);
            end
        end else begin
            mag = d[63] ? (~d[63:0] + 64'h1) : d[63:0];
        end
        if (mag == 64'h0) begin
            return {d[79] & (f == FPRS_FMT_BCD), 79'h0};
        end
        norm = mag;
        for (int k = 0; k < 63; k++) begin
            if (!norm[63]) begin
                norm = norm << 1;
                lz = lz + 7'h1;
            end
        end
        return {(f == FPRS_FMT_BCD) ? d[79] : d[63],
                15'(16'h3FFF + 16'h3F - 16'(lz)), norm};
    endfunction

    // Truncating conversion to a 64-bit signed integer or 18-digit decimal
    function automatic logic [FPRS_MEM_W-1:0] fromExt(input fprs_fmt_t f,
                                                       input logic [FPRS_EXT_W-1:0] v);
        logic [63:0] ival;
        logic [14:0] e;
        logic [79:0] out;
        ival = 64'h0;
        e = v[78:64];
        out = 80'h0;
        if (f == FPRS_FMT_EXT) begin
            return v;
        end
        if (e >= 15'h3FFF && e <= 15'h403E) begin
            ival = v[63:0] >> (15'h403E - e);
        end
        if (f == FPRS_FMT_INT) begin
            return {16'h0, v[79] ? (~ival + 64'h1) : ival};
        end
        for (int k = 0; k < 18; k++) begin
            out[k*4 +: 4] = 4'(ival % 64'hA);
            ival = ival / 64'hA;
        end
        out[79] = v[79];
        return out;
    endfunction

    assign loadExt = toExt(req.fmt, req.data);
    assign storeMem = fromExt(req.fmt, slotMem_q[headIdx]);

    // ****************************************
    // Stack top pointer
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            top_q <= FPRS_TOP_RST;
        end else if (req.valid) begin
            unique case (req.op)
                FPRS_OP_PUSH: top_q <= topPush;
                FPRS_OP_POP: top_q <= topPop;
                default: top_q <= top_q;
            endcase
        end
    end

    // ****************************************
    // Data slots
    // ****************************************
    // No reset on storage: contents persist across calls and returns
    always_ff @(posedge core_clk) begin
        if (req.valid) begin
            unique case (req.op)
                FPRS_OP_PUSH: slotMem_q[topPush] <= loadExt;
                FPRS_OP_LOAD: slotMem_q[headIdx] <= loadExt;
                FPRS_OP_WRITE: slotMem_q[relPhys] <= req.data;
                FPRS_OP_SWAP: begin
                    slotMem_q[headIdx] <= slotMem_q[relPhys];
                    slotMem_q[relPhys] <= slotMem_q[headIdx];
                end
                FPRS_OP_MEDIA_WR: begin
                    slotMem_q[req.relIdx] <= {FPRS_MEDIA_EXP, req.data[FPRS_MEDIA_W-1:0]};
                end
                default: ;
            endcase
        end
    end

    // Occupancy per slot; one loop body per physical slot
    for (genvar s = 0; s < FPRS_SLOTS; s++) begin : g_full
        assign slotFull_d[s] = !req.valid ? slotFull_q[s] :
            (req.op == FPRS_OP_PUSH && topPush == 3'(s)) ? 1'b1 :
            (req.op == FPRS_OP_POP && top_q == 3'(s)) ? 1'b0 :
            (req.op == FPRS_OP_MEDIA_WR) ? 1'b1 :
            slotFull_q[s];
    end

    // One flop vector, so the occupancy word has a single driver
    always_ff @(posedge core_clk) begin
        if (reset) begin
            slotFull_q <= '0;
        end else begin
            slotFull_q <= slotFull_d;
        end
    end

    // ****************************************
    // Special registers
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            controlWord <= FPRS_CTRL_RST;
        end else if (ctrlWrEn) begin
            controlWord <= ctrlWrData;
        end
    end

    // Overflow set wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            exc_q <= 1'b0;
        end else if (overflowHit) begin
            exc_q <= 1'b1;
        end else if (clearExc) begin
            exc_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            stackOverflow <= 1'b0;
        end else begin
            stackOverflow <= overflowHit;
        end
    end

    // Status mirrors the pointer and flags one cycle after they change
    always_ff @(posedge core_clk) begin
        if (reset) begin
            statusWord <= FPRS_STATUS_RST;
        end else begin
            statusWord <= FPRS_STATUS_RST;
            statusWord[FPRS_TOP_MSB:FPRS_TOP_LSB] <= top_q;
            statusWord[FPRS_C1_BIT] <= exc_q;
            statusWord[FPRS_SF_BIT] <= exc_q;
            statusWord[FPRS_IE_BIT] <= exc_q;
        end
    end

    for (genvar t = 0; t < FPRS_SLOTS; t++) begin : g_tag
        assign tag_d[2*t +: 2] = slotFull_q[t] ? FPRS_TAG_VALID : FPRS_TAG_EMPTY;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tagWord <= FPRS_TAG_RST;
        end else begin
            tagWord <= tag_d;
        end
    end

    // Pointers are captured for every issued request from the common stream
    always_ff @(posedge core_clk) begin
        if (reset) begin
            lastInstrPtr <= '0;
            lastOperandPtr <= '0;
            lastOpcode <= '0;
        end else if (req.valid) begin
            lastInstrPtr <= req.instrPtr;
            lastOperandPtr <= req.operandPtr;
            lastOpcode <= req.opcode;
        end
    end

    // ****************************************
    // Response
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rsp <= '0;
        end else begin
            rsp.valid <= req.valid && (req.op == FPRS_OP_POP || req.op == FPRS_OP_STORE);
            rsp.data <= storeMem;
            rsp.headValue <= slotMem_q[relPhys];
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence pushReq;
        req.valid && req.op == FPRS_OP_PUSH;
    endsequence
    sequence mediaReq;
        req.valid && req.op == FPRS_OP_MEDIA_WR;
    endsequence
    sequence writeReq;
        req.valid && req.op == FPRS_OP_WRITE;
    endsequence

    chk_push_decrement: assert property (@(posedge core_clk) disable iff (reset)
        pushReq |=> top_q == $past(top_q) - 3'h1)
        else $error("push did not decrement pointer");
    chk_pop_increment: assert property (@(posedge core_clk) disable iff (reset)
        req.valid && req.op == FPRS_OP_POP |=> top_q == $past(top_q) + 3'h1)
        else $error("pop did not increment pointer");
    chk_plain_keeps: assert property (@(posedge core_clk) disable iff (reset)
        req.valid && (req.op == FPRS_OP_LOAD || req.op == FPRS_OP_STORE) |=> $stable(top_q))
        else $error("plain access moved pointer");
    chk_wrap_seven: assert property (@(posedge core_clk) disable iff (reset)
        pushReq and top_q == 3'h0 |=> top_q == 3'h7)
        else $error("pointer did not wrap to seven");
    chk_overflow_flag: assert property (@(posedge core_clk) disable iff (reset)
        pushReq and slotFull_q[topPush] |=> stackOverflow ##1 statusWord[FPRS_SF_BIT])
        else $error("overflow not reported");
    chk_push_writes: assert property (@(posedge core_clk) disable iff (reset)
        pushReq and req.fmt == FPRS_FMT_EXT |=> slotMem_q[top_q] == $past(req.data))
        else $error("push wrote wrong slot");
    chk_status_top: assert property (@(posedge core_clk) disable iff (reset)
        ##1 statusWord[FPRS_TOP_MSB:FPRS_TOP_LSB] == $past(top_q))
        else $error("status pointer field stale");
    chk_swap_exchange: assert property (@(posedge core_clk) disable iff (reset)
        req.valid && req.op == FPRS_OP_SWAP && req.relIdx != 3'h0
        |=> slotMem_q[$past(relPhys)] == $past(slotMem_q[headIdx]))
        else $error("swap did not exchange");
    chk_pop_data: assert property (@(posedge core_clk) disable iff (reset)
        req.valid && req.op == FPRS_OP_POP && req.fmt == FPRS_FMT_EXT
        |=> rsp.valid && rsp.data == $past(slotMem_q[headIdx]))
        else $error("pop returned wrong data");

    // ****************************************
    // Quiet paths, side registers and further data paths
    // ****************************************
    chk_no_false_ovf: assert property (@(posedge core_clk) disable iff (reset)
        pushReq and !slotFull_q[topPush] |=> !stackOverflow)
        else $error("overflow raised on empty slot");
    chk_clear_flag: assert property (@(posedge core_clk) disable iff (reset)
        clearExc && !overflowHit |=> ##1 !statusWord[FPRS_IE_BIT])
        else $error("exception flag not cleared");
    chk_store_data: assert property (@(posedge core_clk) disable iff (reset)
        req.valid && req.op == FPRS_OP_STORE && req.fmt == FPRS_FMT_EXT
        |=> rsp.valid && rsp.data == $past(slotMem_q[top_q]))
        else $error("store returned wrong data");
    chk_media_write: assert property (@(posedge core_clk) disable iff (reset)
        mediaReq |=> slotMem_q[$past(req.relIdx)]
            == {FPRS_MEDIA_EXP, $past(req.data[FPRS_MEDIA_W-1:0])})
        else $error("media write missed its slot");
    chk_write_rel: assert property (@(posedge core_clk) disable iff (reset)
        writeReq |=> slotMem_q[3'($past(top_q) + $past(req.relIdx))] == $past(req.data))
        else $error("relative write missed its slot");
    chk_swap_head: assert property (@(posedge core_clk) disable iff (reset)
        req.valid && req.op == FPRS_OP_SWAP
        |=> slotMem_q[$past(top_q)] == $past(slotMem_q[relPhys]))
        else $error("swap left head unchanged");
    chk_ptr_capture: assert property (@(posedge core_clk) disable iff (reset)
        req.valid |=> lastOpcode == $past(req.opcode) && lastInstrPtr == $past(req.instrPtr))
        else $error("last pointers not captured");
    chk_rsp_quiet: assert property (@(posedge core_clk) disable iff (reset)
        !req.valid |=> !rsp.valid)
        else $error("response without request");
    chk_ctrl_write: assert property (@(posedge core_clk) disable iff (reset)
        ctrlWrEn |=> controlWord == $past(ctrlWrData))
        else $error("control word not written");
    chk_none_stable: assert property (@(posedge core_clk) disable iff (reset)
        req.valid && req.op == FPRS_OP_NONE |=> $stable(top_q))
        else $error("idle request moved pointer");
endmodule // fprs_stack
`default_nettype wire

// ### verification/fprs_core_model.sv
// Purpose: Core issue-side model that drives the register stack request port
// Assumes: Requests launch on the rising edge by non-blocking assignment
// Notes: Pointer and opcode fields derive from data so the bench can predict them
`timescale 1ns/100ps
`default_nettype none
module fprs_core_model (
    output var fprs_pkg::fprs_req_t req
    ,
    input wire logic core_clk
);
    import fprs_pkg::*;
    initial req = '0;
    // ****************************************
    // Issue
    // ****************************************
    // One request then an idle cycle, so valid never changes twice in a step
    task automatic issue(input fprs_op_t op, input fprs_fmt_t fmt, input logic [2:0] rel,
                         input logic [79:0] d);
        fprs_req_t r;
        r = '0;
        r.valid = 1'b1;
        r.op = op;
        r.fmt = fmt;
        r.relIdx = rel;
        r.data = d;
        r.instrPtr = d[31:0];
        r.operandPtr = ~d[31:0];
        r.opcode = d[10:0];
        @(posedge core_clk);
        req <= r;
        @(posedge core_clk);
        req <= '0;
    endtask
endmodule // fprs_core_model
`default_nettype wire

// ### verification/fprs_stack_tb.sv
// Purpose: Self-checking bench for the floating-point register stack
// Assumes: Results follow the hand-over latencies: rsp one cycle, status two
// Notes: Slot contents are predicted from the push order, never read back blindly
`timescale 1ns/100ps
`default_nettype none
module fprs_stack_tb;
    import fprs_pkg::*;
    localparam logic [79:0] BASE = 80'h4000_C000_0000_0000_0000;
    localparam logic [79:0] OVF = 80'h3FFE_1234_5678_9ABC_DEF0;
    localparam logic [79:0] MEDIA_D = 80'h0000_0123_4567_89AB_CDEF;
    logic core_clk, reset, ctrlWrEn, clearExc;
    logic [15:0] ctrlWrData, statusWord, controlWord, tagWord;
    logic [31:0] lastInstrPtr, lastOperandPtr;
    logic [10:0] lastOpcode;
    logic stackOverflow;
    fprs_req_t req;
    fprs_rsp_t rsp;
    int n_fail = 0;
    int samples_checked = 0;

    fprs_core_model u_core (.req(req), .core_clk(core_clk));
    fprs_stack u_dut (.core_clk(core_clk), .reset(reset), .req(req), .ctrlWrData(ctrlWrData),
        .ctrlWrEn(ctrlWrEn), .clearExc(clearExc), .rsp(rsp), .statusWord(statusWord),
        .controlWord(controlWord), .tagWord(tagWord), .lastInstrPtr(lastInstrPtr),
        .lastOperandPtr(lastOperandPtr), .lastOpcode(lastOpcode), .stackOverflow(stackOverflow));

    initial core_clk = 1'b0;
    always #2 core_clk = ~core_clk;

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [79:0] got, input logic [79:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic done(input string name);
        $display("test %s done", name);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Head value comes back one cycle after any valid request
    task automatic peek(input logic [2:0] rel, input logic [79:0] exp);
        u_core.issue(FPRS_OP_NONE, FPRS_FMT_EXT, rel, 80'h0);
        #1;
        check(rsp.headValue, exp);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        settle(1);
        check(statusWord, FPRS_STATUS_RST);
        check(controlWord, FPRS_CTRL_RST);
        check(tagWord, FPRS_TAG_RST);
        check(stackOverflow, 1'b0);
        done("reset");
    endtask
    task automatic t_push_wrap;
        u_core.issue(FPRS_OP_PUSH, FPRS_FMT_EXT, 3'h0, BASE);
        #1;
        check(stackOverflow, 1'b0);
        settle(1);
        check(statusWord[FPRS_TOP_MSB:FPRS_TOP_LSB], 3'h7);
        check(tagWord[15:14], FPRS_TAG_VALID);
        peek(3'h0, BASE);
        done("push_wrap");
    endtask
    // Eight pushes fill every slot, the ninth wraps onto a full one
    task automatic t_fill_overflow;
        for (int k = 1; k < 8; k++)
            u_core.issue(FPRS_OP_PUSH, FPRS_FMT_EXT, 3'h0, BASE + 80'(k));
        for (int i = 0; i < 8; i++)
            peek(3'(i), BASE + 80'(7 - i));
        u_core.issue(FPRS_OP_PUSH, FPRS_FMT_EXT, 3'h0, OVF);
        #1;
        check(stackOverflow, 1'b1);
        settle(1);
        check(stackOverflow, 1'b0);
        check(statusWord[FPRS_TOP_MSB:FPRS_TOP_LSB], 3'h7);
        check({statusWord[FPRS_C1_BIT], statusWord[FPRS_SF_BIT], statusWord[FPRS_IE_BIT]},
            3'h7);
        @(posedge core_clk);
        clearExc <= 1'b1;
        @(posedge core_clk);
        clearExc <= 1'b0;
        settle(2);
        check({statusWord[FPRS_C1_BIT], statusWord[FPRS_SF_BIT], statusWord[FPRS_IE_BIT]},
            3'h0);
        done("fill_overflow");
    endtask
    task automatic t_store_pop;
        u_core.issue(FPRS_OP_STORE, FPRS_FMT_EXT, 3'h0, 80'h0);
        #1;
        check(rsp.valid, 1'b1);
        check(rsp.data, OVF);
        settle(1);
        check(rsp.valid, 1'b0);
        check(statusWord[FPRS_TOP_MSB:FPRS_TOP_LSB], 3'h7);
        u_core.issue(FPRS_OP_POP, FPRS_FMT_EXT, 3'h0, 80'h0);
        #1;
        check(rsp.valid, 1'b1);
        check(rsp.data, OVF);
        settle(1);
        check(statusWord[FPRS_TOP_MSB:FPRS_TOP_LSB], 3'h0);
        check(tagWord[15:14], FPRS_TAG_EMPTY);
        peek(3'h0, BASE + 80'h7);
        done("store_pop");
    endtask
    task automatic t_swap;
        u_core.issue(FPRS_OP_SWAP, FPRS_FMT_EXT, 3'h2, 80'h0);
        peek(3'h0, BASE + 80'h5);
        peek(3'h2, BASE + 80'h7);
        done("swap");
    endtask
    // Integer and decimal values survive a load and store in their own format
    task automatic roundtrip(input fprs_fmt_t fmt, input logic [79:0] d, input logic [79:0] m);
        u_core.issue(FPRS_OP_LOAD, fmt, 3'h0, d);
        u_core.issue(FPRS_OP_STORE, fmt, 3'h0, 80'h0);
        #1;
        check(rsp.data & m, d);
    endtask
    task automatic t_formats;
        roundtrip(FPRS_FMT_INT, 80'h7B, {16'h0, {64{1'b1}}});
        roundtrip(FPRS_FMT_BCD, 80'h456, {8'h80, {72{1'b1}}});
        settle(1);
        check(statusWord[FPRS_TOP_MSB:FPRS_TOP_LSB], 3'h0);
        done("formats");
    endtask
    task automatic t_alias_special;
        u_core.issue(FPRS_OP_MEDIA_WR, FPRS_FMT_EXT, 3'h3, MEDIA_D);
        #1;
        check(lastInstrPtr, MEDIA_D[31:0]);
        check(lastOperandPtr, {~MEDIA_D[31:0]});
        check(lastOpcode, MEDIA_D[10:0]);
        peek(3'h3, {FPRS_MEDIA_EXP, MEDIA_D[63:0]});
        @(posedge core_clk);
        ctrlWrData <= 16'h0A5C;
        ctrlWrEn <= 1'b1;
        @(posedge core_clk);
        ctrlWrEn <= 1'b0;
        settle(1);
        check(controlWord, 16'h0A5C);
        done("alias_special");
    endtask
    // Raw write at head seven plus two lands in slot one, seen after the pop
    task automatic t_write;
        u_core.issue(FPRS_OP_PUSH, FPRS_FMT_EXT, 3'h0, BASE);
        u_core.issue(FPRS_OP_WRITE, FPRS_FMT_INT, 3'h2, OVF);
        u_core.issue(FPRS_OP_POP, FPRS_FMT_EXT, 3'h0, 80'h0);
        #1;
        check(rsp.valid, 1'b1);
        check(rsp.data, BASE);
        peek(3'h1, OVF);
        done("write");
    endtask

    // Hang guard
    initial begin
        repeat (5000) @(posedge core_clk);
        n_fail++;
        report_and_stop();
    end

    initial begin
        reset = 1'b1;
        ctrlWrData = 16'h0000;
        ctrlWrEn = 1'b0;
        clearExc = 1'b0;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        t_reset();
        t_push_wrap();
        t_fill_overflow();
        t_store_pop();
        t_swap();
        t_formats();
        t_alias_special();
        t_write();
        report_and_stop();
    end
endmodule // fprs_stack_tb
`default_nettype wire
